// file: rtl/sfb_bank1_map.vh
/*
 * register offsets, field masks and reset values of the second-bank
 * special register map. included by the map module; definitions only.
 */
`ifndef SFB_BANK1_MAP_VH
`define SFB_BANK1_MAP_VH

// register indices; the byte address is four times the index
`define SFB_IDX_INDIRECT_PORT 8'h80
`define SFB_IDX_OPTION 8'h81
`define SFB_IDX_PC_LOW 8'h82
`define SFB_IDX_STATUS 8'h83
`define SFB_IDX_POINTER 8'h84
`define SFB_IDX_PA_DIR 8'h85
`define SFB_IDX_PB_DIR 8'h86
`define SFB_IDX_PC_HIGH_LATCH 8'h8A
`define SFB_IDX_INT_CTRL 8'h8B
`define SFB_IDX_PIE 8'h8C
`define SFB_IDX_PWR_CTRL 8'h8E
`define SFB_IDX_PB_PULLUP 8'h95
`define SFB_IDX_PB_CHANGE 8'h96
`define SFB_IDX_VREF 8'h9B
`define SFB_IDX_LVD 8'h9C
`define SFB_IDX_ANALOG_SEL 8'h9D
`define SFB_IDX_CONV_REF 8'h9F

// implemented-bit masks; the status mask gives its writable bits
`define SFB_MASK_FULL 8'hFF
`define SFB_MASK_PC_HIGH_LATCH 8'h1F
`define SFB_MASK_PIE 8'hF1
`define SFB_MASK_PWR_CTRL 8'h1B
`define SFB_MASK_VREF 8'h0C
`define SFB_MASK_LVD 8'h3F
`define SFB_MASK_CONV_REF 8'h30
`define SFB_MASK_STATUS_RW 8'hE7

// reset values (unknown bits taken as zero)
`define SFB_RST_OPTION 8'hFF
`define SFB_RST_STATUS 8'h18
`define SFB_RST_POINTER 8'h00
`define SFB_RST_DIR 8'hFF
`define SFB_RST_PULLUP 8'hFF
`define SFB_RST_CHANGE 8'hF0
`define SFB_RST_LVD 8'h05
`define SFB_RST_ZERO 8'h00
// power control: oscillator flag set, watchdog bit from fuse input
`define SFB_PWR_OSC_BIT 3
`define SFB_PWR_WDT_BIT 4
`define SFB_PWR_POR_BIT 1
`define SFB_PWR_BOR_BIT 0

`endif

// file: rtl/sfb_bank1_regs.v
/*
 * second-bank special register map behind an apb slave: decode, storage,
 * reset values and program counter high latch transfer.
 * assumes a single apb master on ref_clk and a core that pulses
 * pc_update when it reloads the program counter.
 */
`timescale 1ns/1ps
`include "sfb_bank1_map.vh"

module sfb_bank1_regs (
    input wire ref_clk,
    input wire arst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire por_cause,
    input wire bor_cause,
    input wire wdt_fuse,
    input wire pc_update,
    input wire [7:0] indirect_rdata,
    output reg [7:0] pointer_out_r,
    output reg [7:0] status_out_r,
    output reg [4:0] pc_upper_r,
    output reg [7:0] indirect_wdata_r,
    output reg indirect_we_r
);

    // register contents, held in byte cells below except power control
    wire [7:0] option_r;
    wire [7:0] pc_low_r;
    wire [7:0] pa_dir_r;
    wire [7:0] pb_dir_r;
    wire [7:0] pc_high_latch_r;
    wire [7:0] int_ctrl_r;
    wire [7:0] pie_r;
    wire [7:0] pb_pullup_r;
    wire [7:0] pb_change_r;
    wire [7:0] vref_r;
    wire [7:0] lvd_r;
    wire [7:0] analog_sel_r;
    wire [7:0] conv_ref_r;
    reg [7:0] pwr_ctrl_r;
    reg cause_seen_r;
    reg [7:0] rd_nxt;

    // bus decode
    wire [7:0] idx;
    wire [7:0] wd;
    wire in_map;
    wire setup;
    wire access;
    wire wr;

    // per-register write strobes
    wire we_indirect;
    wire we_option;
    wire we_pc_low;
    wire we_status;
    wire we_pointer;
    wire we_pa_dir;
    wire we_pb_dir;
    wire we_latch;
    wire we_int_ctrl;
    wire we_pie;
    wire we_pwr;
    wire we_pullup;
    wire we_change;
    wire we_vref;
    wire we_lvd;
    wire we_analog_sel;
    wire we_conv_ref;

    // word index from byte address; low two bits ignored
    // addresses above the map alias nothing
    assign idx = paddr[9:2];
    assign wd = pwdata[7:0];
    assign in_map = (paddr[11:10] == 2'b00);
    assign setup = psel & ~penable;
    // write lands at the edge that completes the access phase
    assign access = psel & penable & pready;
    assign wr = access & pwrite & in_map;

    // no strobe reaches the counter upper byte
    assign we_indirect = wr & (idx == `SFB_IDX_INDIRECT_PORT);
    assign we_option = wr & (idx == `SFB_IDX_OPTION);
    assign we_pc_low = wr & (idx == `SFB_IDX_PC_LOW);
    assign we_status = wr & (idx == `SFB_IDX_STATUS);
    assign we_pointer = wr & (idx == `SFB_IDX_POINTER);
    assign we_pa_dir = wr & (idx == `SFB_IDX_PA_DIR);
    assign we_pb_dir = wr & (idx == `SFB_IDX_PB_DIR);
    assign we_latch = wr & (idx == `SFB_IDX_PC_HIGH_LATCH);
    assign we_int_ctrl = wr & (idx == `SFB_IDX_INT_CTRL);
    assign we_pie = wr & (idx == `SFB_IDX_PIE);
    assign we_pwr = wr & (idx == `SFB_IDX_PWR_CTRL);
    assign we_pullup = wr & (idx == `SFB_IDX_PB_PULLUP);
    assign we_change = wr & (idx == `SFB_IDX_PB_CHANGE);
    assign we_vref = wr & (idx == `SFB_IDX_VREF);
    assign we_lvd = wr & (idx == `SFB_IDX_LVD);
    assign we_analog_sel = wr & (idx == `SFB_IDX_ANALOG_SEL);
    assign we_conv_ref = wr & (idx == `SFB_IDX_CONV_REF);

    always @* begin
        rd_nxt = `SFB_RST_ZERO;
        case (in_map ? idx : 8'h00)
            `SFB_IDX_INDIRECT_PORT: rd_nxt = indirect_rdata;
            `SFB_IDX_OPTION: rd_nxt = option_r;
            `SFB_IDX_PC_LOW: rd_nxt = pc_low_r;
            `SFB_IDX_STATUS: rd_nxt = status_out_r;
            `SFB_IDX_POINTER: rd_nxt = pointer_out_r;
            `SFB_IDX_PA_DIR: rd_nxt = pa_dir_r;
            `SFB_IDX_PB_DIR: rd_nxt = pb_dir_r;
            `SFB_IDX_PC_HIGH_LATCH: rd_nxt = pc_high_latch_r;
            `SFB_IDX_INT_CTRL: rd_nxt = int_ctrl_r;
            `SFB_IDX_PIE: rd_nxt = pie_r;
            `SFB_IDX_PWR_CTRL: rd_nxt = pwr_ctrl_r;
            `SFB_IDX_PB_PULLUP: rd_nxt = pb_pullup_r;
            `SFB_IDX_PB_CHANGE: rd_nxt = pb_change_r;
            `SFB_IDX_VREF: rd_nxt = vref_r;
            `SFB_IDX_LVD: rd_nxt = lvd_r;
            `SFB_IDX_ANALOG_SEL: rd_nxt = analog_sel_r;
            `SFB_IDX_CONV_REF: rd_nxt = conv_ref_r;
            default: rd_nxt = `SFB_RST_ZERO;
        endcase
    end

    // apb answer: one wait-free access phase, read data latched at setup
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= 1'b0;
            if (setup && !pwrite) begin
                prdata <= {24'h00_0000, rd_nxt};
            end
        end
    end

    // common registers kept here
    // indirect port strobe, status and pointer
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_out_r <= `SFB_RST_STATUS;
            pointer_out_r <= `SFB_RST_POINTER;
            indirect_wdata_r <= `SFB_RST_ZERO;
            indirect_we_r <= 1'b0;
        end else begin
            indirect_we_r <= we_indirect;
            if (we_indirect) begin
                indirect_wdata_r <= wd;
            end
            // timeout and power-down flags are read only
            if (we_status) begin
                status_out_r <= (status_out_r & ~`SFB_MASK_STATUS_RW) |
                    (wd & `SFB_MASK_STATUS_RW);
            end
            // pointer feeds the indirect port
            if (we_pointer) begin
                pointer_out_r <= wd;
            end
        end
    end

    sfb_reg8 #(.RST(`SFB_RST_OPTION), .MASK(`SFB_MASK_FULL)) i_option (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .we(we_option),
        .wd(wd),
        .q_r(option_r)
    );

    sfb_reg8 #(.RST(`SFB_RST_ZERO), .MASK(`SFB_MASK_FULL)) i_pc_low (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .we(we_pc_low),
        .wd(wd),
        .q_r(pc_low_r)
    );

    sfb_reg8 #(.RST(`SFB_RST_DIR), .MASK(`SFB_MASK_FULL)) i_pa_dir (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .we(we_pa_dir),
        .wd(wd),
        .q_r(pa_dir_r)
    );

    sfb_reg8 #(.RST(`SFB_RST_DIR), .MASK(`SFB_MASK_FULL)) i_pb_dir (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .we(we_pb_dir),
        .wd(wd),
        .q_r(pb_dir_r)
    );

    sfb_reg8 #(.RST(`SFB_RST_ZERO), .MASK(`SFB_MASK_PC_HIGH_LATCH)) i_latch (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .we(we_latch),
        .wd(wd),
        .q_r(pc_high_latch_r)
    );

    sfb_reg8 #(.RST(`SFB_RST_ZERO), .MASK(`SFB_MASK_FULL)) i_int_ctrl (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .we(we_int_ctrl),
        .wd(wd),
        .q_r(int_ctrl_r)
    );

    sfb_reg8 #(.RST(`SFB_RST_ZERO), .MASK(`SFB_MASK_PIE)) i_pie (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .we(we_pie),
        .wd(wd),
        .q_r(pie_r)
    );

    sfb_reg8 #(.RST(`SFB_RST_PULLUP), .MASK(`SFB_MASK_FULL)) i_pb_pullup (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .we(we_pullup),
        .wd(wd),
        .q_r(pb_pullup_r)
    );

    sfb_reg8 #(.RST(`SFB_RST_CHANGE), .MASK(`SFB_MASK_FULL)) i_pb_change (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .we(we_change),
        .wd(wd),
        .q_r(pb_change_r)
    );

    sfb_reg8 #(.RST(`SFB_RST_ZERO), .MASK(`SFB_MASK_VREF)) i_vref (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .we(we_vref),
        .wd(wd),
        .q_r(vref_r)
    );

    sfb_reg8 #(.RST(`SFB_RST_LVD), .MASK(`SFB_MASK_LVD)) i_lvd (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .we(we_lvd),
        .wd(wd),
        .q_r(lvd_r)
    );

    sfb_reg8 #(.RST(`SFB_RST_DIR), .MASK(`SFB_MASK_FULL)) i_analog_sel (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .we(we_analog_sel),
        .wd(wd),
        .q_r(analog_sel_r)
    );

    sfb_reg8 #(.RST(`SFB_RST_ZERO), .MASK(`SFB_MASK_CONV_REF)) i_conv_ref (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .we(we_conv_ref),
        .wd(wd),
        .q_r(conv_ref_r)
    );

    // power control loads reset cause after release
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwr_ctrl_r <= `SFB_RST_ZERO;
            cause_seen_r <= 1'b0;
        end else if (!cause_seen_r) begin
            cause_seen_r <= 1'b1;
            pwr_ctrl_r <= `SFB_RST_ZERO;
            pwr_ctrl_r[`SFB_PWR_WDT_BIT] <= wdt_fuse;
            pwr_ctrl_r[`SFB_PWR_OSC_BIT] <= 1'b1;
            pwr_ctrl_r[`SFB_PWR_POR_BIT] <= ~por_cause;
            pwr_ctrl_r[`SFB_PWR_BOR_BIT] <= ~bor_cause;
        end else if (we_pwr) begin
            pwr_ctrl_r <= (pwr_ctrl_r & ~`SFB_MASK_PWR_CTRL) |
                (wd & `SFB_MASK_PWR_CTRL);
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_upper_r <= 5'h00;
        end else if (pc_update) begin
            pc_upper_r <= pc_high_latch_r[4:0];
        end
    end

endmodule

// byte register cell: reset value, then masked writes;
// bits outside the mask stay zero, so they read zero
module sfb_reg8 #(
    parameter [7:0] RST = 8'h00,
    parameter [7:0] MASK = 8'hFF
) (
    input wire ref_clk,
    input wire arst_n,
    input wire we,
    input wire [7:0] wd,
    output reg [7:0] q_r
);

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q_r <= RST & MASK;
        end else if (we) begin
            q_r <= wd & MASK;
        end
    end

endmodule

// file: testbench/sfb_bank1_properties.sv
/* timing checks of the bank map at its apb and core ports.
   assumes one apb master on ref_clk. */
`timescale 1ns/1ps
module sfb_bank1_chk (
    input wire ref_clk,
    input wire arst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pc_update,
    input wire [7:0] pointer_out_r,
    input wire [4:0] pc_upper_r,
    input wire [7:0] indirect_wdata_r,
    input wire indirect_we_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // decode helpers
    wire su = psel && !penable;
    wire ac = psel && penable && pready && pwrite;
    wire [7:0] idx = paddr[11:10] == 2'b00 ? paddr[9:2] : 8'h00;
    wire [7:0] pw = pwdata[7:0];
    wire unm = idx inside {[8'h87:8'h89], 8'h8D, [8'h8F:8'h94],
        [8'h97:8'h9A], 8'h9E};
    reg [4:0] lat_r;
    // shadow of the high latch
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) lat_r <= 5'h00;
        else if (ac && idx == 8'h8A) lat_r <= pw[4:0];
    end
    unmapped_zero_a: assert property (
        su && !pwrite && unm |=> prdata == 32'h00000000)
        else $error("unmapped read not zero");
    upper_hold_a: assert property (
        !pc_update |=> $stable(pc_upper_r))
        else $error("upper counter moved without update");
    latch_copy_a: assert property (
        pc_update |=> pc_upper_r == $past(lat_r))
        else $error("upper counter not loaded from latch");
    pointer_load_a: assert property (
        ac && idx == 8'h84 |=> pointer_out_r == $past(pw))
        else $error("pointer not loaded");
    indirect_put_a: assert property (
        ac && idx == 8'h80 |=> indirect_we_r
        && indirect_wdata_r == $past(pw) ##1 !indirect_we_r)
        else $error("indirect write not one strobe");
    unm_c: cover property (su && !pwrite && unm);
    copy_c: cover property (pc_update && lat_r != 5'h00);
    ind_c: cover property (ac && idx == 8'h80);
endmodule
bind sfb_bank1_regs sfb_bank1_chk i_chk (.ref_clk, .arst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pc_update,
    .pointer_out_r, .pc_upper_r, .indirect_wdata_r, .indirect_we_r);

// file: testbench/sfb_bank1_tb_top.sv
/* self-checking bench of the bank map.
   assumes the map answers apb with pready. */
`timescale 1ns/1ps
module sfb_bank1_tb_top;
    logic ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic pc_update = 0, pready, pslverr, we;
    logic por_cause = 1, bor_cause = 0, wdt_fuse = 1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, q;
    logic [7:0] ptr, st, wd, rd;
    logic [4:0] pcu;
    int error_cnt = 0, n_compared = 0;
    // index and reset value
    localparam logic [15:0] rows_c [0:17] = '{16'h805A, 16'h81FF,
        16'h8200, 16'h8318, 16'h8400, 16'h85FF, 16'h86FF, 16'h8A00,
        16'h8B00, 16'h8C00, 16'h8E19, 16'h95FF, 16'h96F0, 16'h9B00,
        16'h9C05, 16'h9DFF, 16'h9F00, 16'h8700};
    sfb_bank1_regs i_dut (.ref_clk, .arst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .por_cause,
        .bor_cause, .wdt_fuse, .pc_update,
        .indirect_rdata(rd), .pointer_out_r(ptr), .status_out_r(st),
        .pc_upper_r(pcu), .indirect_wdata_r(wd), .indirect_we_r(we));
    sfb_core_model i_core (.ref_clk, .pointer(ptr), .wdata(wd), .we,
        .rdata(rd));
    always #20 ref_clk = ~ref_clk;
    task automatic cmp(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    // one apb transfer, read data kept in q
    task automatic apb(input logic w, input logic [9:0] a,
            input logic [7:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        q = prdata;
        cmp("slave error", 32'h00000000, {31'h00000000, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task complete_run;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        cmp("status out", 32'h00000018, {24'h000000, st});
        foreach (rows_c[k]) begin
            apb(1'b0, rows_c[k][15:8], 8'h00);
            cmp("reset read", {24'h000000, rows_c[k][7:0]}, q);
        end
        // ignored write, then latch path
        apb(1'b1, 8'h87, 8'hFF);
        apb(1'b0, 8'h87, 8'h00);
        cmp("unmapped", 32'h00000000, q);
        apb(1'b1, 8'h8A, 8'hFF);
        apb(1'b0, 8'h8A, 8'h00);
        cmp("latch", 32'h0000001F, q);
        cmp("upper before", 32'h00000000, {27'h0000000, pcu});
        @(posedge ref_clk) pc_update <= 1'b1;
        @(posedge ref_clk) pc_update <= 1'b0;
        @(posedge ref_clk);
        cmp("upper after", 32'h0000001F, {27'h0000000, pcu});
        // read-only status flags and unimplemented power bits
        apb(1'b1, 8'h83, 8'h00);
        apb(1'b0, 8'h83, 8'h00);
        cmp("status flags", 32'h00000018, q);
        cmp("status out", 32'h00000018, {24'h000000, st});
        apb(1'b1, 8'h8E, 8'hFF);
        apb(1'b0, 8'h8E, 8'h00);
        cmp("power bits", 32'h0000001B, q);
        // indirect store through pointer
        apb(1'b1, 8'h84, 8'h10);
        apb(1'b1, 8'h80, 8'h3C);
        apb(1'b0, 8'h80, 8'h00);
        cmp("indirect", 32'h0000003C, q);
        // addresses above the map alias nothing
        apb(1'b1, 10'h284, 8'hFF);
        apb(1'b0, 10'h28A, 8'h00);
        cmp("alias", 32'h00000000, q);
        apb(1'b0, 8'h84, 8'h00);
        cmp("pointer", 32'h00000010, q);
        // mid-run reset with the other cause levels
        por_cause <= 1'b0;
        bor_cause <= 1'b1;
        wdt_fuse <= 1'b0;
        @(posedge ref_clk) arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        cmp("upper reset", 32'h00000000, {27'h0000000, pcu});
        apb(1'b0, 8'h8E, 8'h00);
        cmp("cause", 32'h0000000A, q);
        apb(1'b0, 8'h8A, 8'h00);
        cmp("latch reset", 32'h00000000, q);
        apb(1'b0, 8'h84, 8'h00);
        cmp("pointer reset", 32'h00000000, q);
        complete_run;
    end
    // hang guard
    initial begin
        #100000;
        error_cnt++;
        complete_run;
    end
endmodule

// file: testbench/sfb_core_model.sv
/* data memory reached through the indirect port.
   assumes pointer, data and strobe come from the map. */
`timescale 1ns/1ps
module sfb_core_model (
    input wire ref_clk,
    input wire [7:0] pointer,
    input wire [7:0] wdata,
    input wire we,
    output wire [7:0] rdata
);
    reg [7:0] mem [0:255];
    integer i;
    // known fill pattern
    initial for (i = 0; i < 256; i = i + 1) mem[i] = i[7:0] ^ 8'h5A;
    // store and fetch at pointer
    always @(posedge ref_clk) if (we) mem[pointer] <= wdata;
    assign rdata = mem[pointer];
endmodule
